//--- hdl/rsos_map.svh
// register map, field positions, reset values and timing constants of the relay status output selector
`ifndef RSOS_MAP_SVH
`define RSOS_MAP_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define RSOS_OFF_CTRL 12'h000
`define RSOS_OFF_THRESH 12'h004
`define RSOS_OFF_STATUS 12'h008
`define RSOS_OFF_IRQ_STAT 12'h00c
`define RSOS_OFF_IRQ_MASK 12'h010
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define RSOS_CTRL_SEL_LSB 0
`define RSOS_CTRL_SEL_MSB 3
`define RSOS_CTRL_FMT_LSB 4
`define RSOS_CTRL_FMT_MSB 6
`define RSOS_SEL_RESET 4'h1
`define RSOS_FMT_RESET 3'h0
`define RSOS_THRESH_RESET 16'h0000
`define RSOS_MASK_RESET 4'h0
`define RSOS_IRQ_RELAY_ON 0
`define RSOS_IRQ_RELAY_OFF 1
`define RSOS_IRQ_AIN2_LOSS 2
`define RSOS_IRQ_TRIP 3
// ----------------------------------------
// scaling and analog limits
// ----------------------------------------
`define RSOS_THR_FULL 32'h0000_03e8
`define RSOS_AIN2_LOSS_UA 16'h0bb8
`define RSOS_AIN2_LOW_UA 16'h0fa0
`define RSOS_AIN2_HIGH_UA 16'h4e20
`define RSOS_AIN2_V_FS 16'h2710
`define RSOS_AIN2_MA_FS 16'h4e20
`define RSOS_AIN2_LOOP_FS 16'h3e80
`define RSOS_FAULT_AIN2_LOSS 16'h0007
`define RSOS_FAULT_NONE 16'h0000
// ----------------------------------------
// pulse timing
// ----------------------------------------
`define RSOS_CLK_HZ 125000000
`define RSOS_PULSE_SEC 1
`define RSOS_GROUP_SEC 15
`define RSOS_PULSES_VOLT 4'h3
`define RSOS_PULSES_OTEMP 4'h4
`define RSOS_PULSES_OCUR 4'h5
`define RSOS_PULSES_EXT 4'h6
`define RSOS_PULSES_SHORT 4'h7
`endif

//--- hdl/rsos_pkg.sv
// types shared by the relay status output selector
package rsos_pkg;
  typedef enum logic [3:0] {
    RSOS_SEL_RUNNING = 4'h0,
    RSOS_SEL_READY = 4'h1,
    RSOS_SEL_AT_TARGET = 4'h2,
    RSOS_SEL_TRIPPED = 4'h3,
    RSOS_SEL_FREQ_GE = 4'h4,
    RSOS_SEL_CUR_GE = 4'h5,
    RSOS_SEL_FREQ_LT = 4'h6,
    RSOS_SEL_CUR_LT = 4'h7,
    RSOS_SEL_AIN2_GT = 4'h8,
    RSOS_SEL_READY_RUN = 4'h9,
    RSOS_SEL_PULSE = 4'ha
  } rsos_sel_t;

  typedef enum logic [2:0] {
    RSOS_FMT_VOLT = 3'h0,
    RSOS_FMT_MA_0_20 = 3'h1,
    RSOS_FMT_TRIP_4_20 = 3'h2,
    RSOS_FMT_RAMP_4_20 = 3'h3,
    RSOS_FMT_TRIP_20_4 = 3'h4,
    RSOS_FMT_RAMP_20_4 = 3'h5,
    RSOS_FMT_THERMISTOR = 3'h6
  } rsos_fmt_t;

  typedef enum logic [2:0] {
    RSOS_TRIP_NONE = 3'h0,
    RSOS_TRIP_OVERVOLT = 3'h1,
    RSOS_TRIP_UNDERVOLT = 3'h2,
    RSOS_TRIP_OVERTEMP = 3'h3,
    RSOS_TRIP_OVERCURRENT = 3'h4,
    RSOS_TRIP_EXTERNAL = 3'h5,
    RSOS_TRIP_SHORT = 3'h6,
    RSOS_TRIP_OTHER = 3'h7
  } rsos_trip_t;

  typedef struct packed {
    logic motor_enabled;
    logic power_ok;
    logic fault_active;
    rsos_trip_t trip_kind;
  } rsos_status_t;

  typedef struct packed {
    logic [15:0] freq_out;
    logic [15:0] freq_set;
    logic [15:0] motor_current;
    logic [15:0] ain2_level;
  } rsos_meas_t;
endpackage

//--- hdl/rsos_cmp.sv
// threshold scaler and comparator for one measured quantity
`include "rsos_map.svh"
module rsos_cmp #(
  parameter int W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] value,
  input wire logic [W-1:0] full_scale,
  input wire logic [W-1:0] thresh,
  output logic ge,
  output logic gt,
  output logic lt
);
  logic [2*W-1:0] prod;
  logic [2*W-1:0] scaled;
  logic [2*W-1:0] value_w;

  // threshold is tenths of a percent of full scale
  assign prod = {{W{1'b0}}, thresh} * {{W{1'b0}}, full_scale};
  assign scaled = prod / `RSOS_THR_FULL;
  assign value_w = {{W{1'b0}}, value};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ge <= 1'b0;
      gt <= 1'b0;
      lt <= 1'b0;
    end
    else
    begin
      ge <= value_w >= scaled;
      gt <= value_w > scaled;
      lt <= value_w < scaled;
    end
  end
endmodule // rsos_cmp

//--- hdl/rsos_pulse.sv
// trip pulse group generator
`include "rsos_map.svh"
module rsos_pulse #(
  parameter int SEC_CYCLES = `RSOS_PULSE_SEC * `RSOS_CLK_HZ,
  parameter int GROUP_SEC = `RSOS_GROUP_SEC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic active,
  input wire logic [3:0] pulses,
  output logic pulse_out
);
  localparam int TW = $clog2(SEC_CYCLES + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(SEC_CYCLES - 1);
  localparam logic [4:0] SEC_LAST = 5'(GROUP_SEC - 1);
  logic [TW-1:0] tick_reg;
  logic [4:0] sec_reg;
  logic [4:0] span;

  // one second on, one off, per pulse
  assign span = {pulses, 1'b0};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_reg <= '0;
      sec_reg <= '0;
    end
    else if (!active)
    begin
      tick_reg <= '0;
      sec_reg <= '0;
    end
    else if (tick_reg == TICK_LAST)
    begin
      tick_reg <= '0;
      sec_reg <= (sec_reg == SEC_LAST) ? 5'h00 : sec_reg + 5'h01;
    end
    else
    begin
      tick_reg <= tick_reg + {{(TW-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pulse_out <= 1'b0;
    else
      pulse_out <= active && (sec_reg < span) && !sec_reg[0];
  end
endmodule // rsos_pulse

//--- hdl/rsos_relay_select.sv
// relay status output selector top: apb registers, analog input 2 format handling, relay mux
`include "rsos_map.svh"
module rsos_relay_select #(
  parameter int ADDR_W = 12,
  parameter int W = 16,
  parameter int SEC_CYCLES = `RSOS_PULSE_SEC * `RSOS_CLK_HZ,
  parameter int GROUP_SEC = `RSOS_GROUP_SEC,
  parameter logic [W-1:0] FREQ_FS = 16'h1f40,
  parameter logic [W-1:0] CUR_FS = 16'h2710
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire rsos_pkg::rsos_status_t drive_status,
  input wire rsos_pkg::rsos_meas_t meas,
  output logic relay_out,
  output logic ain2_loss_trip,
  output logic ain2_ramp_stop,
  output logic [15:0] ain2_fault_code,
  output logic thermistor_format,
  output logic irq
);
  // ----------------------------------------
  // register state
  // ----------------------------------------
  rsos_pkg::rsos_sel_t sel_reg;
  rsos_pkg::rsos_fmt_t fmt_reg;
  logic [W-1:0] thresh_reg;
  logic [3:0] irq_stat_reg;
  logic [3:0] irq_stat_next;
  logic [3:0] irq_mask_reg;
  logic [3:0] irq_clear;
  logic [3:0] irq_event;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic [31:0] rd_word;
  logic rd_hit;
  logic acc_first;
  logic acc_done;
  logic wr_done;
  logic rd_done;

  // ----------------------------------------
  // datapath state
  // ----------------------------------------
  logic relay_reg;
  logic relay_next;
  logic loss_trip_reg;
  logic ramp_stop_reg;
  logic [15:0] fault_code_reg;
  logic therm_reg;
  logic irq_reg;
  logic trip_seen_reg;
  logic [W-1:0] ain2_norm;
  logic [W-1:0] ain2_fs;
  logic ain2_current_loop;
  logic ain2_trip_fmt;
  logic ain2_loss;
  logic trip_present;
  logic [3:0] pulse_count;
  logic pulse_const_on;
  logic pulse_active;
  logic pulse_wave;
  logic freq_ge;
  logic freq_lt;
  logic cur_ge;
  logic cur_lt;
  logic ain2_gt;

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  // one wait state: pready comes from a flop, answer on the second access cycle
  assign acc_first = psel && penable && !pready_reg;
  assign acc_done = psel && penable && pready_reg;
  assign wr_done = acc_done && pwrite;
  assign rd_done = acc_done && !pwrite;

  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (paddr)
      `RSOS_OFF_CTRL:
      begin
        rd_word[`RSOS_CTRL_SEL_MSB:`RSOS_CTRL_SEL_LSB] = sel_reg;
        rd_word[`RSOS_CTRL_FMT_MSB:`RSOS_CTRL_FMT_LSB] = fmt_reg;
      end
      `RSOS_OFF_THRESH:
        rd_word[W-1:0] = thresh_reg;
      `RSOS_OFF_STATUS:
        rd_word[5:0] = {pulse_active, therm_reg, ramp_stop_reg, loss_trip_reg, trip_present, relay_reg};
      `RSOS_OFF_IRQ_STAT:
        rd_word[3:0] = irq_stat_reg;
      `RSOS_OFF_IRQ_MASK:
        rd_word[3:0] = irq_mask_reg;
      default:
        rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready_reg <= 1'b0;
    else
      pready_reg <= acc_first;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end
    else if (acc_first)
    begin
      prdata_reg <= pwrite ? 32'h0000_0000 : rd_word;
      pslverr_reg <= !rd_hit;
    end
    else if (acc_done)
    begin
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sel_reg <= rsos_pkg::rsos_sel_t'(`RSOS_SEL_RESET);
      fmt_reg <= rsos_pkg::rsos_fmt_t'(`RSOS_FMT_RESET);
    end
    else if (wr_done && paddr == `RSOS_OFF_CTRL)
    begin
      sel_reg <= rsos_pkg::rsos_sel_t'(pwdata[`RSOS_CTRL_SEL_MSB:`RSOS_CTRL_SEL_LSB]);
      fmt_reg <= rsos_pkg::rsos_fmt_t'(pwdata[`RSOS_CTRL_FMT_MSB:`RSOS_CTRL_FMT_LSB]);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      thresh_reg <= `RSOS_THRESH_RESET;
    else if (wr_done && paddr == `RSOS_OFF_THRESH)
      thresh_reg <= pwdata[W-1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_mask_reg <= `RSOS_MASK_RESET;
    else if (wr_done && paddr == `RSOS_OFF_IRQ_MASK)
      irq_mask_reg <= pwdata[3:0];
  end

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  // only bits already returned to software are cleared, so a late event survives
  assign irq_clear = (rd_done && paddr == `RSOS_OFF_IRQ_STAT) ? prdata_reg[3:0] : 4'h0;

  always_comb
  begin
    irq_event = 4'h0;
    irq_event[`RSOS_IRQ_RELAY_ON] = relay_next && !relay_reg;
    irq_event[`RSOS_IRQ_RELAY_OFF] = !relay_next && relay_reg;
    irq_event[`RSOS_IRQ_AIN2_LOSS] = ain2_loss && !loss_trip_reg && !ramp_stop_reg;
    irq_event[`RSOS_IRQ_TRIP] = trip_present && !trip_seen_reg;
    irq_stat_next = (irq_stat_reg & ~irq_clear) | irq_event;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_stat_reg <= 4'h0;
      irq_reg <= 1'b0;
      trip_seen_reg <= 1'b0;
    end
    else
    begin
      irq_stat_reg <= irq_stat_next;
      irq_reg <= |(irq_stat_next & irq_mask_reg);
      trip_seen_reg <= trip_present;
    end
  end

  // ----------------------------------------
  // analog input 2 format handling
  // ----------------------------------------
  always_comb
  begin
    ain2_norm = meas.ain2_level;
    ain2_fs = `RSOS_AIN2_V_FS;
    ain2_current_loop = 1'b0;
    ain2_trip_fmt = 1'b0;
    unique case (fmt_reg)
      rsos_pkg::RSOS_FMT_VOLT, rsos_pkg::RSOS_FMT_THERMISTOR:
        ain2_fs = `RSOS_AIN2_V_FS;
      rsos_pkg::RSOS_FMT_MA_0_20:
        ain2_fs = `RSOS_AIN2_MA_FS;
      rsos_pkg::RSOS_FMT_TRIP_4_20, rsos_pkg::RSOS_FMT_RAMP_4_20:
      begin
        ain2_fs = `RSOS_AIN2_LOOP_FS;
        ain2_norm = (meas.ain2_level > `RSOS_AIN2_LOW_UA) ? meas.ain2_level - `RSOS_AIN2_LOW_UA : '0;
        ain2_current_loop = 1'b1;
        ain2_trip_fmt = fmt_reg == rsos_pkg::RSOS_FMT_TRIP_4_20;
      end
      rsos_pkg::RSOS_FMT_TRIP_20_4, rsos_pkg::RSOS_FMT_RAMP_20_4:
      begin
        ain2_fs = `RSOS_AIN2_LOOP_FS;
        // inverted loop: 20 mA reads as zero, 4 mA as full scale
        ain2_norm = (meas.ain2_level < `RSOS_AIN2_HIGH_UA) ? `RSOS_AIN2_HIGH_UA - meas.ain2_level : '0;
        ain2_current_loop = 1'b1;
        ain2_trip_fmt = fmt_reg == rsos_pkg::RSOS_FMT_TRIP_20_4;
      end
      default:
        ain2_fs = `RSOS_AIN2_V_FS;
    endcase
  end

  assign ain2_loss = ain2_current_loop && (meas.ain2_level < `RSOS_AIN2_LOSS_UA);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      loss_trip_reg <= 1'b0;
      ramp_stop_reg <= 1'b0;
      fault_code_reg <= `RSOS_FAULT_NONE;
      therm_reg <= 1'b0;
    end
    else
    begin
      loss_trip_reg <= ain2_loss && ain2_trip_fmt;
      ramp_stop_reg <= ain2_loss && !ain2_trip_fmt;
      fault_code_reg <= (ain2_loss && ain2_trip_fmt) ? `RSOS_FAULT_AIN2_LOSS : `RSOS_FAULT_NONE;
      therm_reg <= fmt_reg == rsos_pkg::RSOS_FMT_THERMISTOR;
    end
  end

  // ----------------------------------------
  // threshold comparators
  // ----------------------------------------
  rsos_cmp #(.W(W)) u_cmp_freq (
    .pclk(pclk),
    .presetn(presetn),
    .value(meas.freq_out),
    .full_scale(FREQ_FS),
    .thresh(thresh_reg),
    .ge(freq_ge),
    .gt(),
    .lt(freq_lt)
  );

  rsos_cmp #(.W(W)) u_cmp_cur (
    .pclk(pclk),
    .presetn(presetn),
    .value(meas.motor_current),
    .full_scale(CUR_FS),
    .thresh(thresh_reg),
    .ge(cur_ge),
    .gt(),
    .lt(cur_lt)
  );

  rsos_cmp #(.W(W)) u_cmp_ain2 (
    .pclk(pclk),
    .presetn(presetn),
    .value(ain2_norm),
    .full_scale(ain2_fs),
    .thresh(thresh_reg),
    .ge(),
    .gt(ain2_gt),
    .lt()
  );

  // ----------------------------------------
  // trip pulse pattern
  // ----------------------------------------
  assign trip_present = drive_status.trip_kind != rsos_pkg::RSOS_TRIP_NONE;

  always_comb
  begin
    pulse_count = 4'h0;
    pulse_const_on = 1'b0;
    unique case (drive_status.trip_kind)
      rsos_pkg::RSOS_TRIP_NONE:
        pulse_count = 4'h0;
      rsos_pkg::RSOS_TRIP_OVERVOLT, rsos_pkg::RSOS_TRIP_UNDERVOLT:
        pulse_count = `RSOS_PULSES_VOLT;
      rsos_pkg::RSOS_TRIP_OVERTEMP:
        pulse_count = `RSOS_PULSES_OTEMP;
      rsos_pkg::RSOS_TRIP_OVERCURRENT:
        pulse_count = `RSOS_PULSES_OCUR;
      rsos_pkg::RSOS_TRIP_EXTERNAL:
        pulse_count = `RSOS_PULSES_EXT;
      rsos_pkg::RSOS_TRIP_SHORT:
        pulse_count = `RSOS_PULSES_SHORT;
      rsos_pkg::RSOS_TRIP_OTHER:
        pulse_const_on = 1'b1;
    endcase
  end

  // group timing restarts when the trip or the pulse selection goes away
  assign pulse_active = (sel_reg == rsos_pkg::RSOS_SEL_PULSE) && trip_present && !pulse_const_on;

  rsos_pulse #(.SEC_CYCLES(SEC_CYCLES), .GROUP_SEC(GROUP_SEC)) u_pulse (
    .pclk(pclk),
    .presetn(presetn),
    .active(pulse_active),
    .pulses(pulse_count),
    .pulse_out(pulse_wave)
  );

  // ----------------------------------------
  // relay selection
  // ----------------------------------------
  always_comb
  begin
    unique case (sel_reg)
      rsos_pkg::RSOS_SEL_RUNNING:
        relay_next = drive_status.motor_enabled;
      rsos_pkg::RSOS_SEL_READY:
        relay_next = drive_status.power_ok && !drive_status.fault_active;
      rsos_pkg::RSOS_SEL_AT_TARGET:
        relay_next = meas.freq_out == meas.freq_set;
      rsos_pkg::RSOS_SEL_TRIPPED:
        relay_next = drive_status.fault_active;
      rsos_pkg::RSOS_SEL_FREQ_GE:
        relay_next = freq_ge;
      rsos_pkg::RSOS_SEL_CUR_GE:
        relay_next = cur_ge;
      rsos_pkg::RSOS_SEL_FREQ_LT:
        relay_next = freq_lt;
      rsos_pkg::RSOS_SEL_CUR_LT:
        relay_next = cur_lt;
      rsos_pkg::RSOS_SEL_AIN2_GT:
        relay_next = ain2_gt;
      rsos_pkg::RSOS_SEL_READY_RUN:
        relay_next = drive_status.power_ok && drive_status.motor_enabled;
      rsos_pkg::RSOS_SEL_PULSE:
        relay_next = pulse_wave || (trip_present && pulse_const_on);
      default:
        relay_next = 1'b0;
    endcase
  end

  // a single flop drives the relay, so only one condition ever reaches it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      relay_reg <= 1'b0;
    else
      relay_reg <= relay_next;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign relay_out = relay_reg;
  assign ain2_loss_trip = loss_trip_reg;
  assign ain2_ramp_stop = ramp_stop_reg;
  assign ain2_fault_code = fault_code_reg;
  assign thermistor_format = therm_reg;
  assign irq = irq_reg;
endmodule // rsos_relay_select

//--- bench/rsos_relay_select_props.sv
// concurrent assertions for the relay status output selector
module rsos_relay_select_props #(
  parameter int ADDR_W = 12,
  parameter int SEC_CYCLES = 8,
  parameter int GROUP_SEC = 15
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire rsos_pkg::rsos_status_t drive_status,
  input wire rsos_pkg::rsos_meas_t meas,
  input wire logic relay_out,
  input wire logic ain2_loss_trip,
  input wire logic ain2_ramp_stop,
  input wire logic [15:0] ain2_fault_code,
  input wire logic thermistor_format,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] sel_s;
  logic [2:0] fmt_s;
  int hi_cnt;
  logic pmode;
  // ----------------------------------------
  // shadow of the control word, taken at the completion edge
  // ----------------------------------------
  assign pmode = sel_s == 4'ha && drive_status.trip_kind inside {[3'h1:3'h6]};
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      sel_s <= 4'h1;
      fmt_s <= 3'h0;
    end
    else if (psel && penable && pready && pwrite && !pslverr && paddr == '0)
    begin
      sel_s <= pwdata[3:0];
      fmt_s <= pwdata[6:4];
    end
  // run length of a pulse; long pulses would be missed by a per-edge check
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      hi_cnt <= 0;
    else if (pmode && relay_out)
      hi_cnt <= hi_cnt + 1;
    else
      hi_cnt <= 0;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  apb_wait_a: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("apb answer not after one wait state");
  unused_code_a: assert property (sel_s > 4'ha |=> !relay_out)
    else $error("unused selection drives relay");
  run_route_a: assert property (sel_s == 4'h0 |=> relay_out == $past(drive_status.motor_enabled))
    else $error("running route wrong");
  ready_route_a: assert property (sel_s == 4'h1 |=> relay_out ==
    ($past(drive_status.power_ok) && !$past(drive_status.fault_active)))
    else $error("ready route wrong");
  target_route_a: assert property (sel_s == 4'h2 |=> relay_out == ($past(meas.freq_out) == $past(meas.freq_set)))
    else $error("at target route wrong");
  fault_route_a: assert property (sel_s == 4'h3 |=> relay_out == $past(drive_status.fault_active))
    else $error("tripped route wrong");
  enabled_route_a: assert property (sel_s == 4'h9 |=> relay_out ==
    ($past(drive_status.power_ok) && $past(drive_status.motor_enabled)))
    else $error("ready to run route wrong");
  pulse_width_a: assert property (hi_cnt <= SEC_CYCLES)
    else $error("trip pulse too long");
  other_trip_a: assert property ((sel_s == 4'ha && drive_status.trip_kind == 3'h7)[*2] |=> relay_out)
    else $error("other trip not constant on");
  pulse_idle_a: assert property ((sel_s == 4'ha && drive_status.trip_kind == 3'h0)[*3] |=> !relay_out)
    else $error("relay active without trip");
  loss_trip_a: assert property ((fmt_s == 3'h2 || fmt_s == 3'h4) && meas.ain2_level < 16'h0bb8
    |=> ain2_loss_trip && ain2_fault_code == 16'h0007)
    else $error("loop loss did not trip");
  ramp_stop_a: assert property ((fmt_s == 3'h3 || fmt_s == 3'h5) && meas.ain2_level < 16'h0bb8
    |=> ain2_ramp_stop && !ain2_loss_trip)
    else $error("loop loss did not ramp");
  therm_fmt_a: assert property (fmt_s == 3'h6 |=> thermistor_format)
    else $error("thermistor format not flagged");
  cover property (pmode && relay_out);
  cover property (ain2_loss_trip);
  cover property (irq);
endmodule // rsos_relay_select_props

//--- bench/rsos_relay_contacts.sv
// model of the relay contacts across the two output terminals
module rsos_relay_contacts (
  input wire logic relay_out,
  output logic link_closed
);
  timeunit 1ns;
  timeprecision 1ps;
  // no contact bounce modelled: the bench checks link_closed levels only, and counts edges on relay_out
  always_comb link_closed = relay_out;
endmodule // rsos_relay_contacts

//--- bench/tb_relay_status_output_select.sv
// self-checking testbench of the relay status output selector
module tb_relay_status_output_select;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SEC = 8;
  localparam int GRP = 15;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, relay_out, ain2_loss_trip, ain2_ramp_stop, thermistor_format, irq, link_closed;
  logic [15:0] ain2_fault_code;
  rsos_pkg::rsos_status_t st = '0;
  rsos_pkg::rsos_meas_t ms = '0;
  int err_total = 0;
  int cmp_count = 0;
  logic [31:0] rd;
  logic er;
  logic prev;
  int rises, highs;
  int npulse [6] = '{3, 3, 4, 5, 6, 7};
  always #4 pclk = ~pclk;
  rsos_relay_select #(.SEC_CYCLES(SEC), .GROUP_SEC(GRP)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .drive_status(st), .meas(ms), .relay_out(relay_out), .ain2_loss_trip(ain2_loss_trip),
    .ain2_ramp_stop(ain2_ramp_stop), .ain2_fault_code(ain2_fault_code), .thermistor_format(thermistor_format),
    .irq(irq));
  rsos_relay_contacts u_contacts (.relay_out(relay_out), .link_closed(link_closed));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // no local limit: a slave that never answers is caught by the watchdog
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic run_row(input logic [3:0] sel, input logic [2:0] fmt, input logic [2:0] s3,
    input logic [15:0] fo, input logic [15:0] fs, input logic [15:0] cu, input logic [15:0] ai, input logic exp);
    apb(1'b1, 12'h000, {25'h0, fmt, sel});
    st <= {s3, 3'h0};
    ms <= {fo, fs, cu, ai};
    repeat (4) @(posedge pclk);
    chk_bit(relay_out, exp);
    chk_bit(link_closed, exp);
  endtask
  task automatic fmt_row(input logic [2:0] fmt, input logic [15:0] ai, input logic [2:0] exp);
    apb(1'b1, 12'h000, {25'h0, fmt, 4'h1});
    ms <= {48'h0, ai};
    repeat (3) @(posedge pclk);
    chk_bit(ain2_loss_trip, exp[2]);
    chk_bit(ain2_ramp_stop, exp[1]);
    chk_bit(thermistor_format, exp[0]);
    chk_word({16'h0, ain2_fault_code}, exp[2] ? 32'h7 : 32'h0);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk_word(rd, 32'h1);
    apb(1'b0, 12'h004, 32'h0);
    chk_word(rd, 32'h0);
    apb(1'b0, 12'h014, 32'h0);
    chk_bit(er, 1'b1);
    apb(1'b0, 12'h00c, 32'h0);
    chk_word(rd, 32'h0);
    apb(1'b1, 12'h000, 32'h3);
    st <= {3'b001, 3'h0};
    repeat (4) @(posedge pclk);
    chk_bit(irq, 1'b0);
    apb(1'b1, 12'h010, 32'h1);
    repeat (2) @(posedge pclk);
    chk_bit(irq, 1'b1);
    apb(1'b0, 12'h00c, 32'h0);
    chk_word(rd, 32'h1);
    repeat (2) @(posedge pclk);
    chk_bit(irq, 1'b0);
    apb(1'b1, 12'h004, 32'h1f4);
    apb(1'b0, 12'h004, 32'h0);
    chk_word(rd, 32'h1f4);
    run_row(4'h0, 3'h0, 3'b100, 16'h0, 16'h0, 16'h0, 16'h0, 1'b1);
    run_row(4'h0, 3'h0, 3'b010, 16'h0, 16'h0, 16'h0, 16'h0, 1'b0);
    run_row(4'h1, 3'h0, 3'b010, 16'h0, 16'h0, 16'h0, 16'h0, 1'b1);
    run_row(4'h1, 3'h0, 3'b011, 16'h0, 16'h0, 16'h0, 16'h0, 1'b0);
    run_row(4'h2, 3'h0, 3'b000, 16'h04d2, 16'h04d2, 16'h0, 16'h0, 1'b1);
    run_row(4'h2, 3'h0, 3'b000, 16'h04d2, 16'h04d3, 16'h0, 16'h0, 1'b0);
    run_row(4'h3, 3'h0, 3'b001, 16'h0, 16'h0, 16'h0, 16'h0, 1'b1);
    run_row(4'h3, 3'h0, 3'b110, 16'h0, 16'h0, 16'h0, 16'h0, 1'b0);
    run_row(4'h4, 3'h0, 3'b000, 16'h0fa0, 16'h0, 16'h0, 16'h0, 1'b1);
    run_row(4'h4, 3'h0, 3'b000, 16'h0f9f, 16'h0, 16'h0, 16'h0, 1'b0);
    run_row(4'h6, 3'h0, 3'b000, 16'h0f9f, 16'h0, 16'h0, 16'h0, 1'b1);
    run_row(4'h6, 3'h0, 3'b000, 16'h0fa0, 16'h0, 16'h0, 16'h0, 1'b0);
    run_row(4'h5, 3'h0, 3'b000, 16'h0, 16'h0, 16'h1388, 16'h0, 1'b1);
    run_row(4'h5, 3'h0, 3'b000, 16'h0, 16'h0, 16'h1387, 16'h0, 1'b0);
    run_row(4'h7, 3'h0, 3'b000, 16'h0, 16'h0, 16'h1387, 16'h0, 1'b1);
    run_row(4'h7, 3'h0, 3'b000, 16'h0, 16'h0, 16'h1388, 16'h0, 1'b0);
    run_row(4'h8, 3'h0, 3'b000, 16'h0, 16'h0, 16'h0, 16'h1389, 1'b1);
    run_row(4'h8, 3'h0, 3'b000, 16'h0, 16'h0, 16'h0, 16'h1388, 1'b0);
    run_row(4'h8, 3'h2, 3'b000, 16'h0, 16'h0, 16'h0, 16'h2ee1, 1'b1);
    run_row(4'h8, 3'h4, 3'b000, 16'h0, 16'h0, 16'h0, 16'h2ee1, 1'b0);
    run_row(4'h8, 3'h4, 3'b000, 16'h0, 16'h0, 16'h0, 16'h2edf, 1'b1);
    run_row(4'h8, 3'h1, 3'b000, 16'h0, 16'h0, 16'h0, 16'h2711, 1'b1);
    run_row(4'h9, 3'h0, 3'b110, 16'h0, 16'h0, 16'h0, 16'h0, 1'b1);
    run_row(4'h9, 3'h0, 3'b010, 16'h0, 16'h0, 16'h0, 16'h0, 1'b0);
    run_row(4'hc, 3'h0, 3'b110, 16'h0, 16'h0, 16'h0, 16'h0, 1'b0);
    fmt_row(3'h2, 16'h0bb7, 3'b100);
    fmt_row(3'h2, 16'h0bb8, 3'b000);
    fmt_row(3'h4, 16'h0bb7, 3'b100);
    fmt_row(3'h3, 16'h0bb7, 3'b010);
    fmt_row(3'h5, 16'h0bb7, 3'b010);
    fmt_row(3'h0, 16'h0bb7, 3'b000);
    fmt_row(3'h6, 16'h0bb7, 3'b001);
    apb(1'b0, 12'h008, 32'h0);
    chk_word(rd, 32'h11);
    apb(1'b0, 12'h00c, 32'h0);
    chk_word(rd, 32'h7);
    apb(1'b1, 12'h000, 32'ha);
    st <= '0;
    repeat (3) @(posedge pclk);
    chk_bit(relay_out, 1'b0);
    // two whole group periods, so the repeat is seen as well as the count
    for (int k = 1; k <= 6; k++)
    begin
      st.trip_kind <= rsos_pkg::rsos_trip_t'(k);
      rises = 0;
      highs = 0;
      prev = 1'b0;
      repeat (2 * GRP * SEC)
      begin
        @(posedge pclk);
        if (relay_out === 1'b1 && prev !== 1'b1)
          rises++;
        if (relay_out === 1'b1)
          highs++;
        prev = relay_out;
      end
      st.trip_kind <= rsos_pkg::RSOS_TRIP_NONE;
      repeat (4) @(posedge pclk);
      chk_bit(relay_out, 1'b0);
      chk_word(32'(rises), 32'(2 * npulse[k-1]));
      chk_word(32'(highs), 32'(2 * SEC * npulse[k-1]));
    end
    st.trip_kind <= rsos_pkg::RSOS_TRIP_OTHER;
    repeat (40) @(posedge pclk);
    chk_bit(relay_out, 1'b1);
    give_verdict();
  end
  initial
  begin
    #100000;
    err_total++;
    give_verdict();
  end
endmodule // tb_relay_status_output_select
bind rsos_relay_select rsos_relay_select_props #(.ADDR_W(ADDR_W), .SEC_CYCLES(SEC_CYCLES), .GROUP_SEC(GROUP_SEC))
  u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .drive_status(drive_status), .meas(meas),
  .relay_out(relay_out), .ain2_loss_trip(ain2_loss_trip), .ain2_ramp_stop(ain2_ramp_stop),
  .ain2_fault_code(ain2_fault_code), .thermistor_format(thermistor_format), .irq(irq));
